// File: hdl/esm_top.sv
// encoder simulation (A/B/R outputs) and master encoder input with gear ratio
// Behaviour
// - zero pulse delayed by offset quadrature periods
// - offset defaults 5, range -8191 to 8192
// - offset sign selects zero pulse direction
// - no zero pulse if offset small or wrong; here only offset 0 stops it, out of range offsets are clamped
// - sync input low enables, high disables pulse
// - more than 500 us before first pulse
// - zero pulse at same angle every revolution
// - ratio mode lines 32 to 65536, code 0-11
// - tracks A, B 90 degrees, plus R
// - output filter with its own time, 1 ms
// - counts scale with resolver pole pairs
// - position handled at 16 bit resolution
// - output pulse frequency at most 500 kHz
// - master source TTL or HTL
// - master shape A/B or pulse/direction
// - master lines 2^n, n from 5 to 13
// - signed numerator, unsigned denominator gear ratio
// - ratio adopted synchronously when enabled
// - direct mode forwards encoder squares one-to-one
`include "esm_consts.svh"
module esm_top
	import esm_pkg::*;
#(
	parameter int GUARD_CYC = `ESM_ZP_GUARD_US * `ESM_CLK_MHZ + 1
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               srst,
	// motor position, 16 bits per pole pair cycle
	input  wire logic [15:0]        motor_pos,
	// direct mode squares from the sin/cos comparators
	input  wire logic               direct_a,
	input  wire logic               direct_b,
	input  wire logic               direct_r,
	// simulation configuration
	input  wire logic               sim_mode,
	input  wire logic               sim_cfg_load,
	input  wire logic [3:0]         sim_lines_per_rev,
	input  wire logic signed [14:0] zero_pulse_offset_periods,
	input  wire logic [15:0]        sim_output_filter_time,
	input  wire logic               zero_pulse_sync_input,
	// simulated encoder outputs
	output logic                    enc_a,
	output logic                    enc_b,
	output logic                    enc_r,
	// master encoder pins
	input  wire logic               ttl_a,
	input  wire logic               ttl_b,
	input  wire logic               htl_a,
	input  wire logic               htl_b,
	// master configuration
	input  wire logic               master_input_source,
	input  wire logic               master_signal_shape,
	input  wire logic [3:0]         master_lines_per_rev,
	input  wire logic signed [17:0] ratio_numerator,
	input  wire logic [16:0]        ratio_denominator,
	input  wire logic               ratio_adopt_sync,
	input  wire logic               ratio_load,
	// master results
	output logic signed [31:0]      gear_pos,
	output logic                    ratio_pending
);
	localparam int EDGE_NS  = 1000000 / (`ESM_MAX_OUT_KHZ * 4);
	localparam int EDGE_CYC = (EDGE_NS * `ESM_CLK_MHZ + 999) / 1000;
	localparam int GW       = $clog2(GUARD_CYC + 1);

	if (GUARD_CYC < 1 || EDGE_CYC < 1) begin : g_chk
		$error("esm_top: cycle counts must be at least one");
	end

	// pin synchronisers: stage one feeds stage two only
	logic [7:0] pin_raw;
	logic [7:0] pin_m_r;
	logic [7:0] pin_s_r;
	assign pin_raw = {htl_b, htl_a, ttl_b, ttl_a, zero_pulse_sync_input, direct_r, direct_b, direct_a};
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_m_r <= 8'h00;
			pin_s_r <= 8'h00;
		end else begin
			pin_m_r <= pin_raw;
			pin_s_r <= pin_m_r;
		end
	end
	logic zp_sync_s;
	assign zp_sync_s = pin_s_r[3];

	// configuration held locally; reset brings the defaults
	logic signed [14:0] off_r;
	logic [15:0]        filt_us_r;
	logic [3:0]         lines_code_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			off_r        <= `ESM_ZP_OFF_DEFAULT;
			filt_us_r    <= `ESM_FILT_US_DEFAULT;
			lines_code_r <= `ESM_LINES_DEFAULT;
		end else if (sim_cfg_load) begin
			// out of range values are clamped, not wrapped
			if (zero_pulse_offset_periods < `ESM_ZP_OFF_MIN)
				off_r <= `ESM_ZP_OFF_MIN;
			else
				off_r <= (zero_pulse_offset_periods > `ESM_ZP_OFF_MAX) ? `ESM_ZP_OFF_MAX : zero_pulse_offset_periods;
			filt_us_r    <= sim_output_filter_time;
			lines_code_r <= (sim_lines_per_rev > `ESM_LINES_MAX) ? `ESM_LINES_MAX : sim_lines_per_rev;
		end
	end

	// scale the position to quadrature counts: 4 * 32 * 2^code per cycle
	// the cycle is one pole pair, so p pole pairs give p times the lines
	logic [4:0]  exp_w;
	logic [33:0] wide_w;
	logic [17:0] target_w;
	logic [18:0] mod_w;
	logic [17:0] mask_w;
	assign exp_w    = `ESM_LINES_BASE_EXP + {1'b0, lines_code_r};
	assign wide_w   = {18'h00000, motor_pos} << exp_w;
	assign target_w = wide_w[33:16];
	assign mod_w    = 19'h00001 << exp_w;
	assign mask_w   = 18'(mod_w - 19'h00001);

	// output filter: target sampled once per filter period, zero passes through
	logic [21:0] filt_cnt_r;
	logic [21:0] filt_lim_w;
	logic [17:0] hold_r;
	assign filt_lim_w = 22'(filt_us_r * 22'(`ESM_CLK_MHZ));
	always_ff @(posedge clk) begin
		if (srst) begin
			filt_cnt_r <= 22'h000000;
			hold_r     <= 18'h00000;
		end else if (filt_cnt_r >= filt_lim_w) begin
			filt_cnt_r <= 22'h000000;
			hold_r     <= target_w;
		end else begin
			filt_cnt_r <= filt_cnt_r + 22'h000001;
		end
	end

	// step pacing: a quadrature edge at most every EDGE_CYC cycles
	logic [7:0] pace_r;
	logic       pace_ok;
	assign pace_ok = (pace_r >= 8'(EDGE_CYC - 1));
	logic [17:0] cnt_r;
	logic [17:0] diff_w;
	logic        step_up;
	logic        step_dn;
	assign diff_w  = (hold_r - cnt_r) & mask_w;
	assign step_up = pace_ok && diff_w != 18'h00000 && diff_w <= (mask_w >> 1);
	assign step_dn = pace_ok && diff_w > (mask_w >> 1);
	logic [17:0] cnt_nxt;
	assign cnt_nxt = step_up ? ((cnt_r + 18'h00001) & mask_w) :
	                 step_dn ? ((cnt_r - 18'h00001) & mask_w) : cnt_r;

	always_ff @(posedge clk) begin
		if (srst)
			pace_r <= 8'h00;
		else if (step_up || step_dn)
			pace_r <= 8'h00;
		else if (!pace_ok)
			pace_r <= pace_r + 8'h01;
	end

	// quadrature counter, one step per scaled increment
	logic last_up_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r     <= 18'h00000;
			last_up_r <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			if (step_up || step_dn)
				last_up_r <= step_up;
		end
	end

	// zero pulse point: |offset| periods past index in the offset's direction
	logic [13:0] zp_mag;
	logic [17:0] zp_pt_w;
	logic        zp_ccw;
	logic        zp_hit;
	assign zp_ccw  = off_r[14];
	assign zp_mag  = zp_ccw ? 14'(-off_r) : off_r[13:0];
	assign zp_pt_w = zp_ccw ? ((18'h00000 - {zp_mag, 2'b00}) & mask_w) : ({zp_mag, 2'b00} & mask_w);
	// a fixed count point keeps the pulse at one angle each cycle
	assign zp_hit  = (cnt_nxt == zp_pt_w) && ((step_up && !zp_ccw) || (step_dn && zp_ccw));

	// guard time after enabling before the first pulse may appear
	logic [GW-1:0] guard_r;
	logic          guard_done;
	assign guard_done = (guard_r >= GW'(GUARD_CYC));
	always_ff @(posedge clk) begin
		if (srst || zp_sync_s)
			guard_r <= '0;
		else if (!guard_done)
			guard_r <= guard_r + GW'(1);
	end

	// outputs: direct forwarding or simulated quadrature
	logic zp_allow;
	assign zp_allow = !zp_sync_s && guard_done && zp_mag >= `ESM_ZP_MIN_PERIODS;
	always_ff @(posedge clk) begin
		if (srst) begin
			enc_a <= 1'b0;
			enc_b <= 1'b0;
			enc_r <= 1'b0;
		end else if (sim_mode == ESM_MODE_DIRECT) begin
			enc_a <= pin_s_r[0];
			enc_b <= pin_s_r[1];
			enc_r <= pin_s_r[2];
		end else begin
			// gray order 00,10,11,01: A leads B when counting up
			enc_a <= cnt_nxt[1] ^ cnt_nxt[0];
			enc_b <= cnt_nxt[1];
			if (!zp_allow)
				enc_r <= 1'b0;
			else if (zp_hit)
				enc_r <= 1'b1;
			else if (step_up || step_dn)
				enc_r <= 1'b0;
		end
	end

	// master input: source and shape select, then edge decode
	esm_src_t   src_w;
	esm_shape_t shape_w;
	logic       ma;
	logic       mb;
	logic       ma_prev_r;
	logic       mb_prev_r;
	assign src_w   = esm_src_t'(master_input_source);
	assign shape_w = esm_shape_t'(master_signal_shape);
	assign ma = (src_w == ESM_SRC_HTL) ? pin_s_r[6] : pin_s_r[4];
	assign mb = (src_w == ESM_SRC_HTL) ? pin_s_r[7] : pin_s_r[5];
	always_ff @(posedge clk) begin
		if (srst) begin
			ma_prev_r <= 1'b0;
			mb_prev_r <= 1'b0;
		end else begin
			ma_prev_r <= ma;
			mb_prev_r <= mb;
		end
	end

	logic m_step;
	logic m_up;
	always_comb begin
		m_step = 1'b0;
		m_up   = 1'b0;
		case (shape_w)
			ESM_SHAPE_AB: begin
				m_step = (ma ^ ma_prev_r) ^ (mb ^ mb_prev_r);
				m_up   = ma ^ mb_prev_r;
			end
			ESM_SHAPE_PDIR: begin
				m_step = ma && !ma_prev_r;
				m_up   = mb;
			end
			default: begin
				m_step = 1'b0;
				m_up   = 1'b0;
			end
		endcase
	end

	// weight of one master edge in 16-bit per revolution units
	logic [3:0] ml_exp;
	logic [4:0] wshift;
	assign ml_exp = (master_lines_per_rev < `ESM_ML_EXP_MIN) ? `ESM_ML_EXP_MIN :
	                (master_lines_per_rev > `ESM_ML_EXP_MAX) ? `ESM_ML_EXP_MAX : master_lines_per_rev;
	assign wshift = ((shape_w == ESM_SHAPE_AB) ? `ESM_ML_QUAD_SHIFT : `ESM_ML_PDIR_SHIFT) - {1'b0, ml_exp};

	// master revolution wrap marks the point to adopt a new ratio
	logic [15:0] mpos_r;
	logic [16:0] mw_w;
	logic [16:0] mpos_sum;
	logic        m_wrap;
	assign mw_w     = 17'h00001 << wshift;
	assign mpos_sum = m_up ? ({1'b0, mpos_r} + mw_w) : ({1'b0, mpos_r} - mw_w);
	assign m_wrap   = m_step && mpos_sum[16];
	always_ff @(posedge clk) begin
		if (srst)
			mpos_r <= 16'h0000;
		else if (m_step)
			mpos_r <= mpos_sum[15:0];
	end

	// ratio: shadow registers, adopted at once or at the next wrap
	logic signed [17:0] num_sh_r;
	logic [16:0]        den_sh_r;
	logic signed [17:0] num_r;
	logic [16:0]        den_r;
	logic               adopt;
	assign adopt = ratio_pending && (!ratio_adopt_sync || m_wrap);
	always_ff @(posedge clk) begin
		if (srst) begin
			num_sh_r      <= 18'sh00000;
			den_sh_r      <= 17'h00000;
			ratio_pending <= 1'b0;
		end else if (ratio_load) begin
			num_sh_r      <= (ratio_numerator < `ESM_NUM_MIN) ? `ESM_NUM_MIN :
			                 (ratio_numerator > `ESM_NUM_MAX) ? `ESM_NUM_MAX : ratio_numerator;
			den_sh_r      <= (ratio_denominator > `ESM_DEN_MAX) ? `ESM_DEN_MAX : ratio_denominator;
			ratio_pending <= 1'b1;
		end else if (adopt) begin
			ratio_pending <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			num_r <= 18'sh00000;
			den_r <= 17'h00000;
		end else if (adopt) begin
			num_r <= num_sh_r;
			den_r <= den_sh_r;
		end
	end

	// gear accumulator: one output unit per denominator of accumulated numerator
	// a zero denominator freezes the output; one correction per clock
	logic signed [39:0] acc_r;
	logic signed [39:0] inc_w;
	logic signed [39:0] den_w;
	logic signed [39:0] acc_in;
	assign inc_w  = m_step ? (m_up ? (40'(num_r) <<< wshift) : -(40'(num_r) <<< wshift)) : 40'sh0000000000;
	assign den_w  = 40'($signed({1'b0, den_r}));
	assign acc_in = acc_r + inc_w;
	always_ff @(posedge clk) begin
		if (srst) begin
			acc_r    <= 40'sh0000000000;
			gear_pos <= 32'sh00000000;
		end else if (den_r == 17'h00000) begin
			acc_r <= 40'sh0000000000;
		end else if (acc_in >= den_w) begin
			acc_r    <= acc_in - den_w;
			gear_pos <= gear_pos + 32'sh00000001;
		end else if (acc_in <= -den_w) begin
			acc_r    <= acc_in + den_w;
			gear_pos <= gear_pos - 32'sh00000001;
		end else begin
			acc_r <= acc_in;
		end
	end

	// checking helpers
	logic [7:0] since_r;
	always_ff @(posedge clk) begin
		if (srst || enc_a != $past(enc_a) || enc_b != $past(enc_b))
			since_r <= 8'h00;
		else if (since_r != 8'hFF)
			since_r <= since_r + 8'h01;
	end
	logic dir_s_r;
	always_ff @(posedge clk) begin
		if (srst)
			dir_s_r <= 1'b0;
		else
			dir_s_r <= (sim_mode == ESM_MODE_DIRECT);
	end

	property p_edge_gap;
		@(posedge clk) disable iff (srst)
		(!dir_s_r && sim_mode == ESM_MODE_RATIO && $changed({enc_a, enc_b})) |-> since_r >= 8'(EDGE_CYC - 1);
	endproperty
	a_edge_gap: assert property (p_edge_gap) else $error("quadrature edges closer than the frequency limit");

	property p_one_track;
		@(posedge clk) disable iff (srst)
		($past(sim_mode) == ESM_MODE_RATIO && sim_mode == ESM_MODE_RATIO && $past(sim_mode, 2) == ESM_MODE_RATIO)
		|-> !(enc_a != $past(enc_a) && enc_b != $past(enc_b));
	endproperty
	a_one_track: assert property (p_one_track) else $error("A and B changed together");

	property p_sync_off;
		@(posedge clk) disable iff (srst)
		(zp_sync_s && sim_mode == ESM_MODE_RATIO) |=> !enc_r;
	endproperty
	a_sync_off: assert property (p_sync_off) else $error("zero pulse while sync input high");

	property p_guard;
		@(posedge clk) disable iff (srst)
		($rose(enc_r) && !dir_s_r) |-> $past(guard_done);
	endproperty
	a_guard: assert property (p_guard) else $error("zero pulse inside guard time");

	property p_dir;
		@(posedge clk) disable iff (srst)
		($rose(enc_r) && !dir_s_r) |-> last_up_r == !$past(zp_ccw);
	endproperty
	a_dir: assert property (p_dir) else $error("zero pulse in wrong rotation direction");

	property p_small;
		@(posedge clk) disable iff (srst)
		(zp_mag < `ESM_ZP_MIN_PERIODS && sim_mode == ESM_MODE_RATIO) |=> !$rose(enc_r);
	endproperty
	a_small: assert property (p_small) else $error("zero pulse with too small offset");

	property p_direct;
		@(posedge clk) disable iff (srst)
		(sim_mode == ESM_MODE_DIRECT) |=> (enc_a == $past(pin_s_r[0]) && enc_b == $past(pin_s_r[1]));
	endproperty
	a_direct: assert property (p_direct) else $error("direct mode not forwarding");

	property p_default;
		@(posedge clk) $fell(srst) |-> (off_r == `ESM_ZP_OFF_DEFAULT && lines_code_r == `ESM_LINES_DEFAULT);
	endproperty
	a_default: assert property (p_default) else $error("wrong configuration after reset");

	property p_adopt;
		@(posedge clk) disable iff (srst)
		(ratio_pending && !ratio_load && !ratio_adopt_sync) |=> (!ratio_pending && num_r == $past(num_sh_r));
	endproperty
	a_adopt: assert property (p_adopt) else $error("ratio not adopted at once");

	c_zero_pulse: cover property (@(posedge clk) disable iff (srst) $rose(enc_r) && !dir_s_r);
	c_ccw_pulse:  cover property (@(posedge clk) disable iff (srst) $rose(enc_r) && zp_ccw);
	c_gear_step:  cover property (@(posedge clk) disable iff (srst) $changed(gear_pos));
	c_sync_adopt: cover property (@(posedge clk) disable iff (srst) adopt && ratio_adopt_sync);
endmodule

// File: hdl/esm_consts.svh
// numeric constants of the encoder simulation and master encoder block
`ifndef ESM_CONSTS_SVH
`define ESM_CONSTS_SVH
`define ESM_CLK_MHZ          50
`define ESM_MAX_OUT_KHZ      500
`define ESM_ZP_GUARD_US      500
`define ESM_ZP_OFF_DEFAULT   15'sd5
`define ESM_ZP_OFF_MIN       -15'sd8191
`define ESM_ZP_OFF_MAX       15'sd8192
`define ESM_ZP_MIN_PERIODS   14'd1
`define ESM_FILT_US_DEFAULT  16'd1000
`define ESM_LINES_DEFAULT    4'h5
`define ESM_LINES_MAX        4'hB
`define ESM_LINES_BASE_EXP   5'd7
`define ESM_ML_EXP_MIN       4'h5
`define ESM_ML_EXP_MAX       4'hD
`define ESM_ML_QUAD_SHIFT    5'd14
`define ESM_ML_PDIR_SHIFT    5'd16
`define ESM_NUM_MIN          -18'sd65535
`define ESM_NUM_MAX          18'sd65536
`define ESM_DEN_MAX          17'd65536
`define ESM_POS_BITS         16
`endif

// File: hdl/esm_pkg.sv
// types of the encoder simulation and master encoder block
package esm_pkg;
	typedef enum logic {ESM_SRC_TTL, ESM_SRC_HTL} esm_src_t;
	typedef enum logic {ESM_SHAPE_AB, ESM_SHAPE_PDIR} esm_shape_t;
	typedef enum logic {ESM_MODE_RATIO, ESM_MODE_DIRECT} esm_mode_t;
endpackage

// File: dv/esm_ctrl_model.sv
// receiver model of the controller that reads the simulated tracks
module esm_ctrl_model (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  srst,
	// simulated tracks
	input  wire logic  enc_a,
	input  wire logic  enc_b,
	// decoded count and fault tally
	output int         pos,
	output logic [7:0] bad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph;
	int         gap;
	initial bad = 8'h00;
	// phase of the tracks equals the low two bits of the count
	assign ph = {enc_b, enc_a ^ enc_b};
	// count phase steps; a skipped phase or an edge that comes too soon is a fault
	always @(posedge clk) begin
		gap <= gap + 1;
		if (srst) begin
			pos <= 0;
			gap <= 100;
		end else if (ph != 2'(pos)) begin
			gap <= 1;
			if (2'(ph - 2'(pos)) == 2'h1) pos <= pos + 1;
			else if (2'(ph - 2'(pos)) == 2'h3) pos <= pos - 1;
			else bad <= bad + 8'h01;
			if (gap < 25) bad <= bad + 8'h01;
		end
	end
endmodule

// File: dv/esm_top_bench.sv
// self-checking bench of the encoder simulation and master input block
module esm_top_bench
	import esm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int GC = 20; // short guard so the first zero pulse comes early
	// design inputs, each valued at time zero
	logic               clk = 1'b0;
	logic               srst = 1'b1;
	logic [15:0]        motor_pos = 16'h0000;
	logic               direct_a = 1'b0, direct_b = 1'b0, direct_r = 1'b0;
	logic               sim_mode = 1'b0, sim_cfg_load = 1'b0;
	logic [3:0]         sim_lines_per_rev = 4'h0, master_lines_per_rev = 4'hD;
	logic signed [14:0] zero_pulse_offset_periods = 15'h0002;
	logic [15:0]        sim_output_filter_time = 16'h0000; // filter off: count follows each step
	logic               zero_pulse_sync_input = 1'b0;
	logic               ttl_a = 1'b0, ttl_b = 1'b0, htl_a = 1'b0, htl_b = 1'b0;
	logic               master_input_source = 1'b0, master_signal_shape = 1'b0;
	logic               ratio_adopt_sync = 1'b0, ratio_load = 1'b0;
	logic signed [17:0] ratio_numerator = 18'h00001;
	logic [16:0]        ratio_denominator = 17'h00001;
	// outputs and model results
	logic               enc_a, enc_b, enc_r, ratio_pending, rr;
	logic signed [31:0] gear_pos;
	int                 pos;
	logic [7:0]         bad;
	// bookkeeping
	int                 fails = 0, cmp_count = 0, off, nr;
	int                 zq[$];
	logic signed [31:0] gexp = 0;
	logic [1:0]         mph = 2'h0;

	esm_top #(.GUARD_CYC(GC)) esm_top_inst (.clk, .srst, .motor_pos, .direct_a, .direct_b, .direct_r,
		.sim_mode, .sim_cfg_load, .sim_lines_per_rev, .zero_pulse_offset_periods, .sim_output_filter_time,
		.zero_pulse_sync_input, .enc_a, .enc_b, .enc_r, .ttl_a, .ttl_b, .htl_a, .htl_b, .master_input_source,
		.master_signal_shape, .master_lines_per_rev, .ratio_numerator, .ratio_denominator, .ratio_adopt_sync,
		.ratio_load, .gear_pos, .ratio_pending);
	esm_ctrl_model esm_ctrl_model_inst (.clk, .srst, .enc_a, .enc_b, .pos, .bad);

	// 50 MHz clock
	initial forever #10 clk = ~clk;

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic rst();
		@(posedge clk) srst <= 1'b1;
		cyc(12);
		srst <= 1'b0;
	endtask

	// one load pulse takes lines code and offset together
	task automatic cfg(logic [3:0] c, logic signed [14:0] o);
		@(posedge clk);
		sim_lines_per_rev <= c;
		zero_pulse_offset_periods <= o;
		sim_cfg_load <= 1'b1;
		@(posedge clk) sim_cfg_load <= 1'b0;
	endtask

	// move the motor by whole counts of lines code 0, slower than the output step limit
	task automatic ramp(int n, int d);
		repeat (n) begin
			cyc(30);
			motor_pos <= motor_pos + 16'(d * 512);
		end
		cyc(30);
	endtask

	// one master edge (A/B) or one direction plus pulse; the unselected pins carry noise, except htl_a held low in A/B
	task automatic medge(int d);
		logic [1:0] g;
		cyc(8);
		g = mph + 2'(d); // read after the wait so the previous call's phase has landed
		if (master_signal_shape) begin
			htl_b <= d > 0;
			{ttl_a, ttl_b} <= 2'($urandom);
			cyc(8);
			htl_a <= 1'b1;
			cyc(8);
			htl_a <= 1'b0;
		end else begin
			mph <= g;
			{ttl_a, ttl_b} <= {g[1] ^ g[0], g[1]};
			{htl_a, htl_b} <= {1'b0, 1'($urandom)}; // a kept low so a source switch makes no pulse
		end
	endtask

	// load a ratio, drive edges and check the geared position
	task automatic gear(logic s, int n, int num, int den, int e, int d);
		@(posedge clk);
		master_input_source <= s;
		master_signal_shape <= s;
		master_lines_per_rev <= 4'(n);
		ratio_numerator <= 18'(num);
		ratio_denominator <= 17'(den);
		ratio_load <= 1'b1;
		@(posedge clk) ratio_load <= 1'b0;
		#1 chk("ratio pending set", 1, ratio_pending);
		@(posedge clk) #1 chk("ratio pending clear", 0, ratio_pending);
		repeat (e) medge(d);
		gexp = gexp + num * d * e * (1 << ((s ? 16 : 14) - n)) / den;
		cyc(1200);
		chk("geared position", gexp, gear_pos);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// each zero pulse takes the oldest expected position off the queue
	initial begin
		logic r_q;
		r_q = 1'b0;
		forever begin
			@(posedge clk);
			#1;
			if (sim_mode === 1'b0 && enc_r === 1'b1 && r_q !== 1'b1) begin
				cyc(1);
				#1;
				if (zq.size() == 0) chk("unexpected zero pulse", 0, 1);
				else chk("zero pulse position", zq.pop_front(), pos & 127);
			end
			r_q = enc_r;
		end
	end

	// hang guard, well beyond the expected run length
	initial begin
		#1500000;
		fails++;
		conclude();
	end

	// main sequence
	initial begin
		void'($urandom(41315));
		off = $urandom_range(20, 1);
		nr = $urandom_range(3, 1);
		rst();
		cfg(4'h0, 15'(off));
		cyc(GC + 10);
		zq.push_back(4 * off);
		zq.push_back(4 * off);
		ramp(256, 1);
		chk("count after two turns", 256, pos);
		@(posedge clk) zero_pulse_sync_input <= 1'b1;
		ramp(128, 1);
		@(posedge clk) zero_pulse_sync_input <= 1'b0;
		cfg(4'h0, 15'h0000);
		cyc(GC + 10);
		ramp(128, 1);
		cfg(4'h0, 15'(-off));
		ramp(128, 1);
		zq.push_back(128 - 4 * off);
		zq.push_back(128 - 4 * off);
		ramp(256, -1);
		chk("missing zero pulses", 0, zq.size());
		$display("test zero pulse done");
		for (int c = 0; c < 12; c++) begin
			rst();
			cfg(4'(c), -15'sh0002);
			@(posedge clk) motor_pos <= 16'(1 << (14 - c));
			cyc(1000);
			chk("count for lines code", 32, pos);
			@(posedge clk) motor_pos <= 16'h0000;
		end
		$display("test line codes done");
		rst();
		sim_mode <= 1'b1;
		for (int i = 1; i < 9; i++) begin
			rr = 1'($urandom);
			{direct_a, direct_b, direct_r} <= {i[1] ^ i[0], i[1], rr};
			cyc(30);
			chk("forwarded tracks", {i[1] ^ i[0], i[1], rr}, {enc_a, enc_b, enc_r});
		end
		$display("test direct mode done");
		rst();
		gear(ESM_SRC_TTL, 13, nr, 1, 8, 1);
		gear(ESM_SRC_TTL, 5, 1, 2, 2, -1);
		gear(ESM_SRC_HTL, 13, -2, 1, 4, 1);
		gear(ESM_SRC_HTL, 9, 1, 4, 2, -1);
		$display("test gear ratio done");
		rst();
		@(posedge clk) ratio_adopt_sync <= 1'b1;
		ratio_load <= 1'b1;
		@(posedge clk) ratio_load <= 1'b0;
		cyc(20);
		#1 chk("pending before wrap", 1, ratio_pending);
		medge(-1);
		cyc(8);
		#1 chk("pending after wrap", 0, ratio_pending);
		chk("receiver faults", 0, bad);
		$display("test adopt sync done");
		conclude();
	end
endmodule
